// [mem_model.sv]
// Purpose: byte memory on the far side of the stack engine
// Assumes: one byte moves per mem_ack pulse, ack only while mem_req is high
// Notes: slow adds up to three wait cycles; every write is logged in order
`timescale 1ns/1ps
module mem_model (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic slow,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_r;
  logic [1:0] wait_r;
  logic [23:0] wr_log[$];

  // outside an ack the bus shows the inverse of the last byte, not a copy
  always_comb mem_rdata = mem_ack ? mem[mem_addr] : ~last_r;

  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mem_ack <= 1'b0;
      wait_r <= 2'h0;
      last_r <= 8'h00;
    end else if (mem_ack) begin
      mem_ack <= 1'b0;
      last_r <= mem_rdata;
      if (mem_we) begin
        mem[mem_addr] <= mem_wdata;
        wr_log.push_back({mem_addr, mem_wdata});
      end
    end else if (mem_req) begin
      if (wait_r == 2'h0) begin
        mem_ack <= 1'b1;
        wait_r <= slow ? 2'($urandom_range(3)) : 2'h0;
      end else begin
        wait_r <= wait_r - 2'h1;
      end
    end
  end
endmodule

// [stack_addr_pkg.sv]
// Purpose: shared constants, types and the indexed address adder
// Assumes: one byte moves per memory handshake
// Notes: push goes toward lower addresses
// How it works
// - long branch adds a signed 16-bit displacement to the program counter
// - pc-relative effective address is run-time program counter plus offset
// - only constant-offset indexed references may use the program counter as base
// - load effective address writes the computed address into the pointer
// - hardware and user stack pointers are 16-bit indexable bases
// - interrupt entry and calls stack state through the hardware pointer
// - user stack pointer untouched by interrupts and hardware calls
// - push and pull take a postbyte subset on either stack
// - push decrements the pointer before storing each byte
// - program counter goes first, then the opposite stack pointer
// - push ends with the pointer on the last byte stored
// - interrupt entry stacks registers in the push order
// - unselected registers are skipped, order of the rest kept
// - either stack pointer may be base, also for indirect fetch
// - both index registers may step as extra stack pointers
// - load effective into hardware stack with negative offset reserves space
// - post-increment uses then steps; pre-decrement steps then uses
package stack_addr_pkg;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] PTR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [7:0] CC_RST = 8'h50;
  localparam int CC_ENTIRE = 7;
  localparam int PB_PC = 7;
  localparam logic [7:0] PB_ALL = 8'hff;
  localparam logic [7:0] PB_PC_ONLY = 8'h80;
  localparam int STEP_NUM = 12;
  localparam int STEP_LAST = 11;

  typedef enum logic [3:0] {
    op_none, op_push, op_pull, op_intr, op_call, op_lbra, op_lea, op_ea,
    op_load
  } op_t;
  typedef enum logic [2:0] {
    ix_offset, ix_pcrel, ix_inc1, ix_inc2, ix_dec1, ix_dec2
  } ix_mode_t;
  typedef enum logic [1:0] {ptr_x, ptr_y, ptr_u, ptr_s} ptr_t;
  typedef enum logic [3:0] {
    sel_x, sel_y, sel_u, sel_s, sel_pc, sel_a, sel_b, sel_dp, sel_cc
  } reg_sel_t;
  typedef enum logic [3:0] {
    st_idle = 4'b0001, st_push = 4'b0010, st_pull = 4'b0100,
    st_ind = 4'b1000
  } state_t;

  // push step k -> postbyte bit: pc, other sp, y, x (two bytes each),
  // then dp, b, a, cc
  function automatic logic [2:0] step_bit(input int k);
    unique case (k)
      0, 1: return 3'h7;
      2, 3: return 3'h6;
      4, 5: return 3'h5;
      6, 7: return 3'h4;
      8: return 3'h3;
      9: return 3'h2;
      10: return 3'h1;
      default: return 3'h0;
    endcase
  endfunction

  function automatic logic [11:0] step_mask(input logic [7:0] pb);
    logic [11:0] m;
    m = 12'h000;
    for (int k = 0; k < STEP_NUM; k++) begin
      m[k] = pb[step_bit(k)];
    end
    return m;
  endfunction

  // {found, step}: nearest selected step from start, upward or downward
  function automatic logic [4:0] scan(input logic [11:0] m, input int start,
                                      input logic up);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < STEP_NUM; i++) begin
      if (up) begin
        if (m[i] && i >= start && !r[4]) r = {1'b1, 4'(i)};
      end else if (m[i] && i <= start) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction
endpackage

`timescale 1ns/1ps
module ea_calc (
  input wire stack_addr_pkg::ix_mode_t mode,
  input wire logic [15:0] base_val,
  input wire logic [15:0] program_counter,
  input wire logic [15:0] offset,
  output logic [15:0] ea,
  output logic [15:0] new_base,
  output logic steps_base
);
  import stack_addr_pkg::*;
  always_comb begin
    ea = base_val + offset;
    new_base = base_val;
    steps_base = 1'b0;
    unique case (mode)
      ix_pcrel: ea = program_counter + offset;
      ix_inc1, ix_inc2: begin
        ea = base_val;
        new_base = base_val + ((mode == ix_inc1) ? 16'h0001 : 16'h0002);
        steps_base = 1'b1;
      end
      ix_dec1, ix_dec2: begin
        new_base = base_val - ((mode == ix_dec1) ? 16'h0001 : 16'h0002);
        ea = new_base;
        steps_base = 1'b1;
      end
      default: ea = base_val + offset;
    endcase
  end
endmodule

// [stack_and_pc_relative_addressing_test.sv]
// Purpose: self-checking bench for the stack engine
// Assumes: memory partner in mem_model, commands issued only while idle
// Notes: a register model in the bench tracks every expected value
`timescale 1ns/1ps
module stack_and_pc_relative_addressing_test;
  import stack_addr_pkg::*;
  typedef struct packed {
    logic [15:0] pc, s, u, x, y;
    logic [7:0] a, b, dp, cc;
  } regs_t;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid = 1'b0;
  logic cmd_use_user = 1'b0;
  logic cmd_indirect = 1'b0;
  logic slow = 1'b0;
  op_t cmd_op = op_none;
  ix_mode_t cmd_mode = ix_offset;
  ptr_t cmd_base = ptr_x;
  ptr_t cmd_dest = ptr_x;
  reg_sel_t cmd_sel = sel_x;
  logic [7:0] cmd_postbyte = 8'h00;
  logic [15:0] cmd_offset = 16'h0000;
  logic [15:0] cmd_value = 16'h0000;
  logic [15:0] intr_vector = 16'h0000;
  logic cmd_ready, mem_req, mem_we, mem_ack, done;
  logic [15:0] mem_addr, ea_out, program_counter, hw_sp, user_sp;
  logic [15:0] index_x, index_y;
  logic [7:0] mem_wdata, mem_rdata, acc_a, acc_b;
  logic [7:0] direct_page_reg, condition_code_reg;
  int err_total = 0;
  int n_compared = 0;
  int cycles = 0;
  regs_t r1, r2, e;
  logic [7:0] pb;
  logic usr;
  logic [15:0] sp, ea;
  logic [7:0] corner[5] = '{8'h00, 8'hff, 8'h80, 8'h40, 8'h01};
  logic [15:0] offs[4] = '{16'h7fff, 16'h8000, 16'hffff, 16'h0001};
  logic [23:0] exp_log[$];

  stack_engine u_dut (.core_clk, .sys_rst, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_postbyte, .cmd_use_user, .cmd_mode, .cmd_base, .cmd_dest,
    .cmd_indirect, .cmd_offset, .cmd_sel, .cmd_value, .intr_vector,
    .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_rdata, .mem_ack, .done,
    .ea_out, .program_counter, .hw_sp, .user_sp, .index_x, .index_y,
    .acc_a, .acc_b, .direct_page_reg, .condition_code_reg);
  mem_model u_mem (.core_clk, .sys_rst, .slow, .mem_req, .mem_we,
    .mem_addr, .mem_wdata, .mem_rdata, .mem_ack);

  always #5 core_clk = ~core_clk;

  task automatic complete_run();
    if (err_total == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      err_total++;
      $display("Error %0t: run hung", $time);
      complete_run();
    end
  end

  task automatic cmp(input logic [111:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  function automatic regs_t snap();
    return '{program_counter, hw_sp, user_sp, index_x, index_y, acc_a,
             acc_b, direct_page_reg, condition_code_reg};
  endfunction

  function automatic logic [15:0] get_p(regs_t r, ptr_t p);
    return p == ptr_x ? r.x : p == ptr_y ? r.y : p == ptr_u ? r.u : r.s;
  endfunction

  function automatic regs_t put_p(regs_t r, ptr_t p, logic [15:0] v);
    case (p)
      ptr_x: r.x = v;
      ptr_y: r.y = v;
      ptr_u: r.u = v;
      default: r.s = v;
    endcase
    return r;
  endfunction

  // indexed step: new base kept in the model, effective address returned
  function automatic regs_t step(regs_t r, ix_mode_t m, ptr_t p,
                                 logic [15:0] off, output logic [15:0] a);
    logic [15:0] b;
    logic [15:0] nb;
    b = get_p(r, p);
    nb = m == ix_inc1 ? b + 16'h1 : m == ix_inc2 ? b + 16'h2 :
         m == ix_dec1 ? b - 16'h1 : m == ix_dec2 ? b - 16'h2 : b;
    a = m == ix_pcrel ? r.pc + off : m == ix_offset ? b + off :
        (m == ix_dec1 || m == ix_dec2) ? nb : b;
    return put_p(r, p, nb);
  endfunction

  // expected write stream of a push, returns the final pointer
  function automatic logic [15:0] build(regs_t r, logic [7:0] p, logic us);
    logic [15:0] s;
    logic [15:0] w[4];
    logic [7:0] c[4];
    s = us ? r.u : r.s;
    w = '{r.pc, us ? r.s : r.u, r.y, r.x};
    c = '{r.dp, r.b, r.a, r.cc};
    exp_log.delete();
    for (int k = 0; k < 4; k++) begin
      if (p[7-k]) begin
        s--;
        exp_log.push_back({s, w[k][7:0]});
        s--;
        exp_log.push_back({s, w[k][15:8]});
      end
    end
    for (int k = 0; k < 4; k++) begin
      if (p[3-k]) begin
        s--;
        exp_log.push_back({s, c[k]});
      end
    end
    return s;
  endfunction

  task automatic cmp_log();
    cmp(112'(u_mem.wr_log.size()), 112'(exp_log.size()), "write count");
    foreach (exp_log[i]) begin
      if (i < u_mem.wr_log.size())
        cmp(112'(u_mem.wr_log[i]), 112'(exp_log[i]), "write byte");
    end
    u_mem.wr_log.delete();
  endtask

  task automatic issue(input op_t op);
    int n;
    logic busy;
    @(negedge core_clk);
    cmp(112'(cmd_ready), 112'(1'b1), "ready when idle");
    cmd_op = op;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    // only memory commands keep the engine busy past the accept edge
    busy = op == op_intr || op == op_call || (op == op_lea && cmd_indirect)
           || ((op == op_push || op == op_pull) && cmd_postbyte != 8'h00);
    cmp(112'({cmd_ready, done}), 112'({2{!busy}}), "ready and done");
    n = 0;
    while (done !== 1'b1 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    if (n == 500) begin
      err_total++;
      $display("Error %0t: no done", $time);
    end
  endtask

  task automatic set_regs(input regs_t r);
    reg_sel_t sl[9];
    logic [15:0] v[9];
    sl = '{sel_pc, sel_s, sel_u, sel_x, sel_y, sel_a, sel_b, sel_dp, sel_cc};
    v = '{r.pc, r.s, r.u, r.x, r.y, 16'(r.a), 16'(r.b), 16'(r.dp),
          16'(r.cc)};
    for (int i = 0; i < 9; i++) begin
      cmd_sel = sl[i];
      cmd_value = v[i];
      issue(op_load);
    end
  endtask

  initial begin
    void'($urandom(67));
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    cmp(snap(), {PC_RST, {4{PTR_RST}}, {3{BYTE_RST}}, CC_RST}, "reset");
    for (int i = 0; i < 16; i++) begin
      pb = i < 5 ? corner[i] : 8'($urandom);
      usr = i[0];
      slow = 1'($urandom_range(1));
      r1 = 112'({$urandom, $urandom, $urandom, $urandom});
      set_regs(r1);
      u_mem.wr_log.delete();
      cmd_postbyte = pb;
      cmd_use_user = usr;
      sp = build(r1, pb, usr);
      issue(op_push);
      e = put_p(r1, usr ? ptr_u : ptr_s, sp);
      cmp(snap(), e, "after push");
      cmp_log();
      r2 = 112'({$urandom, $urandom, $urandom, $urandom});
      r2 = put_p(r2, usr ? ptr_u : ptr_s, sp);
      set_regs(r2);
      issue(op_pull);
      e = r2;
      if (pb[7]) e.pc = r1.pc;
      if (pb[6]) e = put_p(e, usr ? ptr_s : ptr_u, usr ? r1.s : r1.u);
      if (pb[5]) e.y = r1.y;
      if (pb[4]) e.x = r1.x;
      if (pb[3]) e.dp = r1.dp;
      if (pb[2]) e.b = r1.b;
      if (pb[1]) e.a = r1.a;
      if (pb[0]) e.cc = r1.cc;
      e = put_p(e, usr ? ptr_u : ptr_s, usr ? r1.u : r1.s);
      cmp(snap(), e, "after pull");
    end
    slow = 1'b1;
    intr_vector = 16'($urandom);
    e.cc[CC_ENTIRE] = 1'b1;
    sp = build(e, PB_ALL, 1'b0);
    issue(op_intr);
    cmp_log();
    e.s = sp;
    e.pc = intr_vector;
    cmp(snap(), e, "after interrupt");
    cmd_offset = 16'($urandom);
    sp = build(e, PB_PC_ONLY, 1'b0);
    issue(op_call);
    cmp_log();
    e.s = sp;
    e.pc = e.pc + cmd_offset;
    cmp(snap(), e, "after call");
    foreach (offs[i]) begin
      cmd_offset = offs[i];
      issue(op_lbra);
      e.pc = e.pc + offs[i];
      cmp(snap(), e, "long branch");
    end
    for (int m = 0; m < 6; m++) begin
      for (int b = 0; b < 4; b++) begin
        cmd_mode = ix_mode_t'(m);
        cmd_base = ptr_t'(b);
        cmd_offset = 16'($urandom);
        e = step(e, cmd_mode, cmd_base, cmd_offset, ea);
        issue(op_ea);
        cmp(112'(ea_out), 112'(ea), "indexed address");
        cmp(snap(), e, "indexed step");
      end
    end
    for (int d = 0; d < 5; d++) begin
      cmd_dest = d < 4 ? ptr_t'(d) : ptr_s;
      cmd_mode = d[0] ? ix_pcrel : ix_offset;
      cmd_base = d < 4 ? ptr_t'($urandom_range(3)) : ptr_s;
      cmd_offset = d < 4 ? 16'($urandom) : 16'hffef;
      e = step(e, cmd_mode, cmd_base, cmd_offset, ea);
      e = put_p(e, cmd_dest, ea);
      issue(op_lea);
      cmp(112'(ea_out), 112'(ea), "lea address");
      cmp(snap(), e, "lea result");
    end
    cmd_postbyte = 8'h10;
    cmd_use_user = 1'b0;
    sp = build(e, 8'h10, 1'b0);
    issue(op_push);
    cmp_log();
    e.s = sp;
    cmd_indirect = 1'b1;
    cmd_mode = ix_offset;
    cmd_base = ptr_s;
    cmd_dest = ptr_y;
    cmd_offset = 16'h0000;
    issue(op_lea);
    cmd_indirect = 1'b0;
    e.y = e.x;
    cmp(112'(ea_out), 112'(e.s), "indirect address");
    cmp(snap(), e, "indirect pointer");
    complete_run();
  end
endmodule

// [stack_engine.sv]
// Purpose: register set, stack push/pull sequencer, relative addressing
// Assumes: memory answers each byte request with a one-cycle mem_ack
// Notes: one command at a time; cmd_ready is high only while idle
`timescale 1ns/1ps
module stack_engine (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire stack_addr_pkg::op_t cmd_op,
  input wire logic [7:0] cmd_postbyte,
  input wire logic cmd_use_user,
  input wire stack_addr_pkg::ix_mode_t cmd_mode,
  input wire stack_addr_pkg::ptr_t cmd_base,
  input wire stack_addr_pkg::ptr_t cmd_dest,
  input wire logic cmd_indirect,
  input wire logic [15:0] cmd_offset,
  input wire stack_addr_pkg::reg_sel_t cmd_sel,
  input wire logic [15:0] cmd_value,
  input wire logic [15:0] intr_vector,
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output logic done,
  output logic [15:0] ea_out,
  output logic [15:0] program_counter,
  output logic [15:0] hw_sp,
  output logic [15:0] user_sp,
  output logic [15:0] index_x,
  output logic [15:0] index_y,
  output logic [7:0] acc_a,
  output logic [7:0] acc_b,
  output logic [7:0] direct_page_reg,
  output logic [7:0] condition_code_reg
);
  import stack_addr_pkg::*;

  logic [15:0] pc_r, s_r, u_r, x_r, y_r;
  logic [7:0] a_r, b_r, dp_r, cc_r;
  state_t state_r;
  logic [3:0] step_r;
  logic [15:0] sp_r, tgt_r, ea_r;
  logic [11:0] mask_r;
  logic [7:0] hi_r;
  logic use_user_r, hw_only_r, load_pc_r, req_r, we_r, done_r;
  logic [15:0] addr_r;
  logic [7:0] wdata_r;
  ptr_t dest_r;

  logic accept;
  logic [15:0] base_val, ea, new_base, own_sp, oth_sp;
  logic steps_base;
  logic [7:0] pb_new;
  logic [11:0] mask_new;
  logic [4:0] first_up, first_dn, nxt_up, nxt_dn;
  logic fin_push, fin_pull, fin_ind;

  assign cmd_ready = (state_r == st_idle);
  assign accept = cmd_valid && cmd_ready;

  // x, y, u, s all serve as base, pc through pc-relative mode
  always_comb begin
    unique case (cmd_base)
      ptr_x: base_val = x_r;
      ptr_y: base_val = y_r;
      ptr_u: base_val = u_r;
      default: base_val = s_r;
    endcase
  end

  ea_calc ea_calc_i (
    .mode(cmd_mode),
    .base_val(base_val),
    .program_counter(pc_r),
    .offset(cmd_offset),
    .ea(ea),
    .new_base(new_base),
    .steps_base(steps_base)
  );

  function automatic logic [7:0] step_byte(input logic [3:0] k,
      input logic [15:0] p, o, y, x, input logic [7:0] dp, b, a, cc);
    unique case (k)
      4'h0: return p[7:0];
      4'h1: return p[15:8];
      4'h2: return o[7:0];
      4'h3: return o[15:8];
      4'h4: return y[7:0];
      4'h5: return y[15:8];
      4'h6: return x[7:0];
      4'h7: return x[15:8];
      4'h8: return dp;
      4'h9: return b;
      4'ha: return a;
      default: return cc;
    endcase
  endfunction

  // hardware entries always use s and the full set or pc alone
  always_comb begin
    unique case (cmd_op)
      op_intr: pb_new = PB_ALL;
      op_call: pb_new = PB_PC_ONLY;
      default: pb_new = cmd_postbyte;
    endcase
  end
  assign mask_new = step_mask(pb_new);
  assign own_sp = (cmd_op == op_push || cmd_op == op_pull) && cmd_use_user
                  ? u_r : s_r;
  assign oth_sp = use_user_r ? s_r : u_r;
  assign first_up = scan(mask_new, 0, 1'b1);
  assign first_dn = scan(mask_new, STEP_LAST, 1'b0);
  assign nxt_up = scan(mask_r, int'(step_r) + 1, 1'b1);
  assign nxt_dn = scan(mask_r, int'(step_r) - 1, 1'b0);
  assign fin_push = (state_r == st_push) && mem_ack && !nxt_up[4];
  assign fin_pull = (state_r == st_pull) && mem_ack && !nxt_dn[4];
  assign fin_ind = (state_r == st_ind) && mem_ack && step_r[0];

  // sequencer
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= st_idle;
      step_r <= 4'h0;
      sp_r <= PTR_RST;
      mask_r <= 12'h000;
      use_user_r <= 1'b0;
      hw_only_r <= 1'b0;
      load_pc_r <= 1'b0;
      tgt_r <= PC_RST;
      dest_r <= ptr_x;
      hi_r <= BYTE_RST;
      req_r <= 1'b0;
      we_r <= 1'b0;
      addr_r <= PTR_RST;
      wdata_r <= BYTE_RST;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      unique case (state_r)
        st_idle: if (accept) begin
          use_user_r <= (cmd_op == op_push || cmd_op == op_pull) &&
                        cmd_use_user;
          hw_only_r <= (cmd_op == op_intr || cmd_op == op_call);
          load_pc_r <= (cmd_op == op_intr || cmd_op == op_call);
          tgt_r <= (cmd_op == op_intr) ? intr_vector : pc_r + cmd_offset;
          mask_r <= mask_new;
          dest_r <= cmd_dest;
          if ((cmd_op == op_push || cmd_op == op_intr ||
               cmd_op == op_call) && first_up[4]) begin
            state_r <= st_push;
            step_r <= first_up[3:0];
            sp_r <= own_sp - 16'h0001;
            addr_r <= own_sp - 16'h0001;
            wdata_r <= step_byte(first_up[3:0], pc_r,
                         cmd_use_user && cmd_op == op_push ? s_r : u_r,
                         y_r, x_r, dp_r, b_r, a_r, cc_r);
            req_r <= 1'b1;
            we_r <= 1'b1;
          end else if (cmd_op == op_pull && first_dn[4]) begin
            state_r <= st_pull;
            step_r <= first_dn[3:0];
            sp_r <= own_sp;
            addr_r <= own_sp;
            req_r <= 1'b1;
            we_r <= 1'b0;
          end else if (cmd_op == op_lea && cmd_indirect) begin
            state_r <= st_ind;
            step_r <= 4'h0;
            addr_r <= ea;
            req_r <= 1'b1;
            we_r <= 1'b0;
          end else begin
            done_r <= 1'b1;
          end
        end
        st_push: if (mem_ack) begin
          if (nxt_up[4]) begin
            step_r <= nxt_up[3:0];
            sp_r <= sp_r - 16'h0001;
            addr_r <= sp_r - 16'h0001;
            wdata_r <= step_byte(nxt_up[3:0], pc_r, oth_sp, y_r, x_r,
                                 dp_r, b_r, a_r, cc_r);
          end else begin
            state_r <= st_idle;
            req_r <= 1'b0;
            we_r <= 1'b0;
            done_r <= 1'b1;
          end
        end
        st_pull: if (mem_ack) begin
          sp_r <= sp_r + 16'h0001;
          if (nxt_dn[4]) begin
            step_r <= nxt_dn[3:0];
            addr_r <= sp_r + 16'h0001;
          end else begin
            state_r <= st_idle;
            req_r <= 1'b0;
            done_r <= 1'b1;
          end
        end
        st_ind: if (mem_ack) begin
          if (!step_r[0]) begin
            hi_r <= mem_rdata;
            step_r <= 4'h1;
            addr_r <= addr_r + 16'h0001;
          end else begin
            state_r <= st_idle;
            req_r <= 1'b0;
            done_r <= 1'b1;
          end
        end
        default: state_r <= st_idle;
      endcase
    end
  end

  // register set; later assignments win inside one cycle
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_r <= PC_RST;
      s_r <= PTR_RST;
      u_r <= PTR_RST;
      x_r <= PTR_RST;
      y_r <= PTR_RST;
      a_r <= BYTE_RST;
      b_r <= BYTE_RST;
      dp_r <= BYTE_RST;
      cc_r <= CC_RST;
    end else begin
      if (accept) begin
        if (cmd_op == op_load) begin
          unique case (cmd_sel)
            sel_x: x_r <= cmd_value;
            sel_y: y_r <= cmd_value;
            sel_u: u_r <= cmd_value;
            sel_s: s_r <= cmd_value;
            sel_pc: pc_r <= cmd_value;
            sel_a: a_r <= cmd_value[7:0];
            sel_b: b_r <= cmd_value[7:0];
            sel_dp: dp_r <= cmd_value[7:0];
            default: cc_r <= cmd_value[7:0];
          endcase
        end
        if (cmd_op == op_lbra) pc_r <= pc_r + cmd_offset;
        if (cmd_op == op_intr) cc_r[CC_ENTIRE] <= 1'b1;
        if ((cmd_op == op_lea || cmd_op == op_ea) && steps_base) begin
          unique case (cmd_base)
            ptr_x: x_r <= new_base;
            ptr_y: y_r <= new_base;
            ptr_u: u_r <= new_base;
            default: s_r <= new_base;
          endcase
        end
        if (cmd_op == op_lea && !cmd_indirect) begin
          unique case (cmd_dest)
            ptr_x: x_r <= ea;
            ptr_y: y_r <= ea;
            ptr_u: u_r <= ea;
            default: s_r <= ea;
          endcase
        end
      end
      if (state_r == st_pull && mem_ack) begin
        unique case (step_r)
          4'h0: pc_r[7:0] <= mem_rdata;
          4'h1: pc_r[15:8] <= mem_rdata;
          4'h2: if (use_user_r) s_r[7:0] <= mem_rdata;
                else u_r[7:0] <= mem_rdata;
          4'h3: if (use_user_r) s_r[15:8] <= mem_rdata;
                else u_r[15:8] <= mem_rdata;
          4'h4: y_r[7:0] <= mem_rdata;
          4'h5: y_r[15:8] <= mem_rdata;
          4'h6: x_r[7:0] <= mem_rdata;
          4'h7: x_r[15:8] <= mem_rdata;
          4'h8: dp_r <= mem_rdata;
          4'h9: b_r <= mem_rdata;
          4'ha: a_r <= mem_rdata;
          default: cc_r <= mem_rdata;
        endcase
      end
      if (fin_push) begin
        if (use_user_r) u_r <= sp_r;
        else s_r <= sp_r;
        if (load_pc_r) pc_r <= tgt_r;
      end
      if (fin_pull) begin
        if (use_user_r) u_r <= sp_r + 16'h0001;
        else s_r <= sp_r + 16'h0001;
      end
      if (fin_ind) begin
        unique case (dest_r)
          ptr_x: x_r <= {hi_r, mem_rdata};
          ptr_y: y_r <= {hi_r, mem_rdata};
          ptr_u: u_r <= {hi_r, mem_rdata};
          default: s_r <= {hi_r, mem_rdata};
        endcase
      end
    end
  end

  // address seen by any indexed memory reference
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) ea_r <= PTR_RST;
    else if (accept && (cmd_op == op_ea || cmd_op == op_lea)) ea_r <= ea;
  end

  assign mem_req = req_r;
  assign mem_we = we_r;
  assign mem_addr = addr_r;
  assign mem_wdata = wdata_r;
  assign done = done_r;
  assign ea_out = ea_r;
  assign program_counter = pc_r;
  assign hw_sp = s_r;
  assign user_sp = u_r;
  assign index_x = x_r;
  assign index_y = y_r;
  assign acc_a = a_r;
  assign acc_b = b_r;
  assign direct_page_reg = dp_r;
  assign condition_code_reg = cc_r;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_push_down: assert property (
    state_r == st_push && mem_ack && nxt_up[4] |=>
      mem_addr == $past(mem_addr) - 16'h0001)
    else $error("push did not step down by one");
  a_pull_up: assert property (
    state_r == st_pull && mem_ack && nxt_dn[4] |=>
      mem_addr == $past(mem_addr) + 16'h0001)
    else $error("pull did not step up by one");
  a_user_kept: assert property (
    hw_only_r && state_r == st_push |=> $stable(user_sp))
    else $error("user pointer moved during hardware stacking");
  a_hw_sp_end: assert property (
    fin_push && hw_only_r |=> hw_sp == $past(mem_addr))
    else $error("hardware pointer not left on last byte");
  a_sp_last: assert property (
    fin_push |=> (use_user_r ? user_sp : hw_sp) == $past(mem_addr))
    else $error("stack pointer not on last byte pushed");
  a_long_branch: assert property (
    accept && cmd_op == op_lbra |=>
      program_counter == $past(program_counter) + $past(cmd_offset))
    else $error("long branch target wrong");
  a_lea_dest: assert property (
    accept && cmd_op == op_lea && !cmd_indirect && cmd_dest == ptr_x
      && !(steps_base && cmd_base != ptr_x) |=> index_x == $past(ea))
    else $error("effective address not loaded");
  a_pcrel_ea: assert property (
    accept && cmd_mode == ix_pcrel |=>
      !$past(cmd_op == op_ea) || ea_out == $past(pc_r + cmd_offset))
    else $error("pc-relative address wrong");
  a_postinc_use: assert property (
    accept && cmd_op == op_ea && cmd_mode == ix_inc1 && cmd_base == ptr_y
      |=> ea_out == $past(y_r) && index_y == $past(y_r) + 16'h0001)
    else $error("post-increment order wrong");
  a_pc_first: assert property (
    accept && cmd_op == op_push && cmd_postbyte[PB_PC] |=>
      mem_wdata == $past(pc_r[7:0]) && mem_we)
    else $error("program counter not stored first");

  c_push: cover property (fin_push && !hw_only_r);
  c_pull: cover property (fin_pull);
  c_intr: cover property (fin_push && hw_only_r && mask_r == 12'hfff);
  c_ind: cover property (fin_ind);
endmodule
